/* File: verilog/jet_pkg.sv */
`default_nettype none
package jet_pkg;

    // ************************************************************
    // Instruction register
    // ************************************************************
    localparam int unsigned IR_W          = 8;
    localparam logic [7:0]  IR_EXTEST     = 8'h00;
    localparam logic [7:0]  IR_SAMPLE     = 8'h02;
    localparam logic [7:0]  IR_HIGHZ      = 8'h06;
    localparam logic [7:0]  IR_BYPASS     = 8'hFF;
    localparam logic [7:0]  IR_CAPTURE    = 8'h01;
    localparam logic [7:0]  IR_RESET_VAL  = IR_BYPASS;
    localparam logic [7:0]  IR_PRIV_FIRST = 8'h20;
    localparam logic [7:0]  IR_PRIV_LAST  = 8'h29;

    // ************************************************************
    // Data registers and pins
    // ************************************************************
    localparam logic        BYPASS_CAPTURE = 1'b0;
    localparam logic        DUMMY_RESET    = 1'b0;
    localparam int unsigned EMU_W          = 2;
    localparam int unsigned TMS_RESET_EDGES = 5;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned TCK_PERIOD_NS  = 800;
    // Sync adds two cycles, edge detect one more
    localparam int unsigned TCK_SYNC_LAT   = 3;
    localparam int unsigned TCK_HALF_CYC   = (TCK_PERIOD_NS / 2) / CLK_PERIOD_NS;

    typedef enum {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UP_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
    } jet_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_b;
    } jet_jtag_in_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } jet_jtag_out_t;

    typedef struct packed {
        logic [EMU_W-1:0] out;
        logic [EMU_W-1:0] oe;
    } jet_emu_out_t;

endpackage : jet_pkg
`default_nettype wire

/* File: verilog/jet_tap.sv */
// How it works
// - An 8-bit instruction register shifts from test data in to test data out in the instruction-shift state.
// - The boundary path is one dummy flip-flop between test data in and out, so loop-back works.
// - No instruction samples or drives any functional pin; there are no boundary cells.
// - The all-ones code is bypass, 06 is high-Z, 02 is sample, 00 is extest, as the controller loads them.
// - Sample and high-Z act only on the dummy cell and never float a functional pin.
// - The two emulation lines are open-collector: they only ever pull low, for wire-OR sharing.
// - The port works as one member of a serial chain with any number of other devices around it.
`timescale 1ns/1ns
`default_nettype none
module jet_tap
    import jet_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire jet_jtag_in_t     i_jtag,
    input  wire logic [EMU_W-1:0] i_emu_pin,
    input  wire logic [EMU_W-1:0] i_emu_pull,
    output var  jet_jtag_out_t    o_jtag,
    output var  jet_emu_out_t     o_emu,
    output logic [EMU_W-1:0]      o_emu_level,
    output logic [IR_W-1:0]       o_ir,
    output logic                  o_boundary_sel
);

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic logic sel_dummy(input logic [IR_W-1:0] code);
        sel_dummy = (code == IR_EXTEST) || (code == IR_SAMPLE) || (code == IR_HIGHZ);
    endfunction

    // ************************************************************
    // Synchronisers
    // ************************************************************
    logic [3:0]       jtag_s1_reg;
    logic [3:0]       jtag_s2_reg;
    logic             tck_d_reg;
    logic [EMU_W-1:0] emu_s1_reg;
    logic             tck_s2;
    logic             tms_s2;
    logic             tdi_s2;
    logic             trst_b_s2;
    logic             tck_rise;
    logic             tck_fall;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            jtag_s1_reg <= 4'h1;
            jtag_s2_reg <= 4'h1;
            tck_d_reg   <= 1'b0;
            emu_s1_reg  <= 2'h3;
            o_emu_level <= 2'h3;
        end else begin
            jtag_s1_reg <= i_jtag;
            jtag_s2_reg <= jtag_s1_reg;
            tck_d_reg   <= jtag_s2_reg[3];
            emu_s1_reg  <= i_emu_pin;
            o_emu_level <= emu_s1_reg;
        end
    end

    assign tck_s2    = jtag_s2_reg[3];
    assign tms_s2    = jtag_s2_reg[2];
    assign tdi_s2    = jtag_s2_reg[1];
    assign trst_b_s2 = jtag_s2_reg[0];
    assign tck_rise  = tck_s2 & ~tck_d_reg;
    assign tck_fall  = ~tck_s2 & tck_d_reg;

    // ************************************************************
    // TAP state, registers and outputs
    // ************************************************************
    jet_state_t      state_reg;
    jet_state_t      state_next;
    logic [IR_W-1:0] ir_sh_reg;
    logic [IR_W-1:0] ir_sh_next;
    logic [IR_W-1:0] ir_next;
    logic            byp_reg;
    logic            byp_next;
    logic            dummy_reg;
    logic            dummy_next;
    jet_jtag_out_t   jtag_out_next;
    jet_emu_out_t    emu_next;

    function automatic jet_state_t tap_step(input jet_state_t s, input logic tms);
        case (s)
            ST_RESET:  tap_step = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   tap_step = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tap_step = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_step = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  tap_step = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_step = tms ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  tap_step = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: tap_step = tms ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  tap_step = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tap_step = tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: tap_step = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  tap_step = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_step = tms ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  tap_step = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: tap_step = tms ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  tap_step = tms ? ST_SEL_DR : ST_IDLE;
            default:   tap_step = ST_RESET;
        endcase
    endfunction

    always_comb begin
        state_next    = state_reg;
        ir_sh_next    = ir_sh_reg;
        ir_next       = o_ir;
        byp_next      = byp_reg;
        dummy_next    = dummy_reg;
        jtag_out_next = o_jtag;
        if (!trst_b_s2) begin
            state_next = ST_RESET;
            ir_next    = IR_RESET_VAL;
        end else if (tck_rise) begin
            state_next = tap_step(state_reg, tms_s2);
            case (state_reg)
                ST_RESET:  ir_next    = IR_RESET_VAL;
                ST_CAP_IR: ir_sh_next = IR_CAPTURE;
                ST_SH_IR:  ir_sh_next = {tdi_s2, ir_sh_reg[IR_W-1:1]};
                ST_UP_IR:  ir_next    = ir_sh_reg;
                // No pins to sample: the dummy cell keeps its value
                ST_CAP_DR: byp_next   = BYPASS_CAPTURE;
                ST_SH_DR: begin
                    if (sel_dummy(o_ir)) begin
                        dummy_next = tdi_s2;
                    end else begin
                        byp_next = tdi_s2;
                    end
                end
                default: ;
            endcase
        end else if (tck_fall) begin
            // Drive on falling edge so the next device samples a stable bit
            jtag_out_next.tdo_oe = (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);
            if (state_reg == ST_SH_IR) begin
                jtag_out_next.tdo = ir_sh_reg[0];
            end else if (state_reg == ST_SH_DR) begin
                jtag_out_next.tdo = sel_dummy(o_ir) ? dummy_reg : byp_reg;
            end
        end
        // Pins pull low only on request, never from the instruction
        emu_next.out = '0;
        emu_next.oe  = i_emu_pull;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg      <= ST_RESET;
            ir_sh_reg      <= IR_CAPTURE;
            o_ir           <= IR_RESET_VAL;
            byp_reg        <= BYPASS_CAPTURE;
            dummy_reg      <= DUMMY_RESET;
            o_jtag         <= '0;
            o_emu          <= '0;
            o_boundary_sel <= 1'b0;
        end else begin
            state_reg      <= state_next;
            ir_sh_reg      <= ir_sh_next;
            o_ir           <= ir_next;
            byp_reg        <= byp_next;
            dummy_reg      <= dummy_next;
            o_jtag         <= jtag_out_next;
            o_emu          <= emu_next;
            o_boundary_sel <= sel_dummy(ir_next);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [2:0] tms_hi_cnt;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tms_hi_cnt <= 3'h0;
        end else if (tck_rise) begin
            tms_hi_cnt <= tms_s2 ? ((tms_hi_cnt == 3'h7) ? 3'h7 : tms_hi_cnt + 3'h1) : 3'h0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_ir_update_load: assert property (
        (tck_rise && trst_b_s2 && state_reg == ST_UP_IR) |=> (o_ir == $past(ir_sh_reg)))
        else $error("instruction not loaded from shift register");
    a_ir_shift_path: assert property (
        (tck_rise && trst_b_s2 && state_reg == ST_SH_IR) |=> (ir_sh_reg[IR_W-1] == $past(tdi_s2))
            && (ir_sh_reg[IR_W-2:0] == $past(ir_sh_reg[IR_W-1:1])))
        else $error("instruction shift path broken");
    a_dummy_loop: assert property (
        (tck_rise && trst_b_s2 && state_reg == ST_SH_DR && o_boundary_sel) |=> (dummy_reg == $past(tdi_s2)))
        else $error("dummy cell did not capture input");
    a_pins_untouched: assert property (
        $changed(o_ir) |=> (o_emu.oe == $past(i_emu_pull)) && (o_emu.out == '0))
        else $error("instruction change disturbed a pin");
    a_decode_codes: assert property (
        o_boundary_sel == ((o_ir == IR_EXTEST) || (o_ir == IR_SAMPLE) || (o_ir == IR_HIGHZ)))
        else $error("instruction decode wrong");
    a_highz_no_float: assert property (
        (o_ir == IR_HIGHZ) |-> ##1 (o_emu.oe == $past(i_emu_pull)))
        else $error("high-Z floated an emulation line");
    a_emu_pull_low: assert property (
        o_emu.out == '0)
        else $error("emulation line driven high");
    a_tdo_enable: assert property (
        (tck_fall && trst_b_s2) |=> (o_jtag.tdo_oe == ($past(state_reg) inside {ST_SH_IR, ST_SH_DR})))
        else $error("data out enable outside shift");
    a_tms_reset: assert property (
        (tms_hi_cnt >= 3'(TMS_RESET_EDGES)) |-> (state_reg == ST_RESET))
        else $error("five high mode bits did not reset");
    a_bypass_default: assert property (
        (tck_rise && trst_b_s2 && state_reg == ST_SH_DR && !o_boundary_sel) |=> (byp_reg == $past(tdi_s2)))
        else $error("unassigned code did not select bypass");

    c_ir_update: cover property (tck_rise && state_reg == ST_UP_IR);
    c_dummy_shift: cover property (tck_rise && state_reg == ST_SH_DR && o_boundary_sel);
    c_bypass_shift: cover property (tck_rise && state_reg == ST_SH_DR && !o_boundary_sel);
    c_trst_reset: cover property (!trst_b_s2 && state_reg != ST_RESET);

endmodule // jet_tap
`default_nettype wire

/* File: bench/jet_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module jet_ctl_model
    import jet_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_tdo,
    input  wire jet_emu_out_t i_emu,
    output var  jet_jtag_in_t o_jtag,
    output logic [EMU_W-1:0]  o_emu_pin
);
    // Pull-up on the shared lines; any enabled driver wins low
    assign o_emu_pin = ~(i_emu.oe & ~i_emu.out);
    initial o_jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_b: 1'b1};
    // Clock stands low between steps; four system clocks per half period
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        o_jtag.tms = tms;
        o_jtag.tdi = tdi;
        repeat (4) @(posedge i_clk);
        #1 o_jtag.tck = 1'b1;
        repeat (2) @(posedge i_clk);
        // Data flips once the rise is taken, so a late sample shows up
        #1 o_jtag.tdi = ~tdi;
        repeat (2) @(posedge i_clk);
        #1 tdo = i_tdo;
        o_jtag.tck = 1'b0;
    endtask
    task automatic tap_reset;
        logic d;
        repeat (TMS_RESET_EDGES) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask
    // Idle to idle; eight bits LSB first, last with mode high
    task automatic scan(input logic ir, input logic [7:0] din, output logic [7:0] dout);
        logic d;
        step(1'b1, 1'b0, d);
        if (ir) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
        step(1'b0, 1'b0, d);
        for (int k = 0; k < 8; k++) step(k == 7, din[k], dout[k]);
        step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask
    task automatic trst_pulse;
        o_jtag.trst_b = 1'b0;
        repeat (10) @(posedge i_clk);
        #1 o_jtag.trst_b = 1'b1;
    endtask
endmodule // jet_ctl_model
`default_nettype wire

/* File: bench/jet_tap_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module jet_tap_tb;
    import jet_pkg::*;
    logic             i_clk = 1'b0;
    logic             i_rst_b = 1'b0;
    jet_jtag_in_t     jtag;
    jet_jtag_out_t    jo;
    jet_emu_out_t     emu;
    logic [EMU_W-1:0] emu_pin;
    logic [EMU_W-1:0] emu_pull = '0;
    logic [EMU_W-1:0] emu_level;
    logic [IR_W-1:0]  ir;
    logic             bsel;
    int               n_fail = 0;
    int               cmp_count = 0;
    always #50 i_clk = ~i_clk;
    jet_tap jet_tap_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_jtag(jtag), .i_emu_pin(emu_pin),
        .i_emu_pull(emu_pull), .o_jtag(jo), .o_emu(emu), .o_emu_level(emu_level), .o_ir(ir),
        .o_boundary_sel(bsel));
    jet_ctl_model jet_ctl_model_inst (.i_clk(i_clk), .i_tdo(jo.tdo), .i_emu(emu), .o_jtag(jtag),
        .o_emu_pin(emu_pin));
    // ************
    // Checks
    // ************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic t_reset;
        chk("ir", IR_RESET_VAL, ir);
        chk("bsel", 8'h00, {7'h0, bsel});
        chk("tdo_oe", 8'h00, {7'h0, jo.tdo_oe});
        chk("emu_level", 8'h03, {6'h0, emu_level});
        $display("test reset done");
    endtask
    // Vendor-private codes stay out of the table
    task automatic t_codes;
        logic [7:0] codes [6] = '{IR_EXTEST, IR_SAMPLE, IR_HIGHZ, IR_BYPASS, 8'h55, 8'hA0};
        logic [7:0] got;
        logic       b;
        foreach (codes[i]) begin
            b = (codes[i] == IR_EXTEST) || (codes[i] == IR_SAMPLE) || (codes[i] == IR_HIGHZ);
            jet_ctl_model_inst.scan(1'b1, codes[i], got);
            chk("capture", IR_CAPTURE, got);
            chk("ir", codes[i], ir);
            chk("bsel", {7'h0, b}, {7'h0, bsel});
            jet_ctl_model_inst.scan(1'b0, 8'hB4, got);
            // Dummy still holds a zero: reset value, or bit 7 of 4B
            chk("dr_first", {7'h34, b ? DUMMY_RESET : BYPASS_CAPTURE}, got);
            jet_ctl_model_inst.scan(1'b0, 8'h4B, got);
            // One-bit delay; dummy keeps bit 7 of B4 through capture
            chk("dr", {7'h4B, b ? 1'b1 : BYPASS_CAPTURE}, got);
            chk("emu_oe", {6'h0, emu_pull}, {6'h0, emu.oe});
        end
        $display("test codes done");
    endtask
    task automatic t_emu;
        for (int p = 0; p < 4; p++) begin
            @(posedge i_clk) #1 emu_pull = 2'(p);
            @(posedge i_clk) #1;
            chk("emu_oe", 8'(p), {6'h0, emu.oe});
            chk("emu_out", 8'h00, {6'h0, emu.out});
            repeat (2) @(posedge i_clk);
            #1 chk("emu_level", 8'(~p & 3), {6'h0, emu_level});
        end
        @(posedge i_clk) #1 emu_pull = 2'b10;
        $display("test emu done");
    endtask
    task automatic t_trst;
        logic [7:0] got;
        jet_ctl_model_inst.scan(1'b1, IR_HIGHZ, got);
        chk("ir", IR_HIGHZ, ir);
        chk("bsel", 8'h01, {7'h0, bsel});
        jet_ctl_model_inst.trst_pulse();
        repeat (2) @(posedge i_clk);
        #1 chk("ir", IR_RESET_VAL, ir);
        chk("bsel", 8'h00, {7'h0, bsel});
        $display("test trst done");
    endtask
    initial begin
        repeat (40000) @(posedge i_clk);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_rst_b = 1'b1;
        t_reset();
        jet_ctl_model_inst.tap_reset();
        t_emu();
        t_codes();
        t_trst();
        close_out();
    end
endmodule // jet_tap_tb
`default_nettype wire
